/* File: spfm_host.sv */
// Host model driving the register bus and control pulses of the monitor.
`timescale 1ns/10ps
module spfm_host
  import spfm_pkg::*;
(
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [DW-1:0] reg_wdata,
  output logic reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  output logic [4:0] ctrl
);
  // Idle bus at time zero; ctrl is clear, on, off, scan start, scan stop.
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'h0;
    reg_wdata = 8'h00;
    reg_rd = 1'h0;
    ctrl = 5'h00;
  end
  // Released lines show the inverse, so a stale value never passes for live data.
  task automatic wr(input logic [7:0] a, input logic [DW-1:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge ref_clk);
    reg_wr = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Data is taken a full cycle after release, since it holds until the next read.
  task automatic rd(input logic [7:0] a, output logic [DW-1:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge ref_clk);
    reg_rd = 1'h0;
    reg_addr = ~a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  task automatic pulse(input logic [4:0] p);
    @(negedge ref_clk);
    ctrl = p;
    @(negedge ref_clk);
    ctrl = 5'h00;
  endtask
endmodule

/* File: spfm_monitor.sv */
// Fault comparison, sticky status and switch control of the supply, pack and temperature monitor.
`timescale 1ns/10ps

// Functional notes
// RQ1 - Each regulator measurement flags supply low when supply is below its minimum.
// RQ2 - Supply low fault opens both switches and stops a running scan in scan mode.
// RQ3 - In scan or idle, regulator current above active threshold flags active overcurrent.
// RQ4 - Active overcurrent fault opens both switches and stops a running scan.
// RQ5 - Low power threshold checked only in low power; idle just updates result.
// RQ6 - Low power overcurrent flagged within 256 ms after entering low power.
// RQ7 - Entering low power with the pump enabled sets pump not ready.
// RQ8 - Back to idle clears pump not ready, restores switches, keeps low power fault.
// RQ9 - Pack above overvoltage threshold sets the pack overvoltage fault.
// RQ10 - Pack overvoltage while charging opens switches and stops scan; otherwise switches stay.
// RQ11 - Pack below undervoltage threshold sets the pack undervoltage fault.
// RQ12 - Pack undervoltage while discharging opens switches and stops scan; otherwise switches stay.
// RQ13 - Die temperature compared to warning and fault thresholds, setting each bit.
// RQ14 - Temperature warning is informational; no switch or scan action.
// RQ15 - Regulator measurement updates only supply and regulator current results.
// RQ16 - Pack measurement updates only pack result; averaging lengthens it elsewhere.
// RQ17 - Temperature measurement updates only the temperature result.
// RQ18 - Temperature fault opens both switches and stops any running scan.
// RQ19 - While temperature fault stands, switch on and scan start are refused.
// RQ20 - Faults stay set until the host clears them; host clears before re-enabling.
// RQ21 - Thresholds are host read/write and used at the next comparison.
module spfm_monitor
  import spfm_pkg::*;
#(
  parameter int LP_EVAL_CYCLES = LP_EVAL_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  input wire spfm_mode_t mode,
  input wire spfm_meas_in_t meas,
  input wire logic charge_current_seen,
  input wire logic discharge_current_seen,
  input wire logic pump_enabled,
  input wire logic fault_clear,
  input wire logic switch_on_req,
  input wire logic switch_off_req,
  input wire logic scan_start_req,
  input wire logic scan_stop_req,
  output logic charge_switch,
  output logic discharge_switch,
  output logic scan_running,
  output spfm_results_t results
);

  localparam int TW = $clog2(LP_EVAL_CYCLES + 1);

  // Decodes a threshold offset into its array index; THR_COUNT means not a threshold.
  function automatic int thr_index(input logic [7:0] a);
    case (a)
      OFS_SUPPLY_MIN: thr_index = THR_SUPPLY;
      OFS_REG_CUR_ACT: thr_index = THR_CUR_ACT;
      OFS_REG_CUR_LP: thr_index = THR_CUR_LP;
      OFS_PACK_OV: thr_index = THR_PACK_OV;
      OFS_PACK_UV: thr_index = THR_PACK_UV;
      OFS_TEMP_WARN: thr_index = THR_TEMP_WARN;
      OFS_TEMP_FAULT: thr_index = THR_TEMP_FAULT;
      default: thr_index = THR_COUNT;
    endcase
  endfunction

  logic [DW-1:0] thr_q [THR_COUNT];
  logic [DW-1:0] thr_d [THR_COUNT];
  logic [DW-1:0] rdata_q, rdata_d;
  logic supply_low_fault_q, supply_low_fault_d;
  logic reg_overcurrent_active_fault_q, reg_overcurrent_active_fault_d;
  logic reg_overcurrent_lowpower_fault_q, reg_overcurrent_lowpower_fault_d;
  logic pack_over_voltage_fault_q, pack_over_voltage_fault_d;
  logic pack_under_voltage_fault_q, pack_under_voltage_fault_d;
  logic die_temp_warning_q, die_temp_warning_d;
  logic die_temp_fault_q, die_temp_fault_d;
  logic pump_not_ready_q, pump_not_ready_d;
  logic chg_sw_q, chg_sw_d, dis_sw_q, dis_sw_d;
  logic chg_save_q, chg_save_d, dis_save_q, dis_save_d;
  logic scan_q, scan_d;
  spfm_mode_t mode_prev_q;
  spfm_results_t res_q, res_d, shadow_q, shadow_d;
  logic [TW-1:0] lp_cnt_q, lp_cnt_d;
  logic lp_pend_q, lp_pend_d;

  // Comparison events of this cycle.
  logic ev_supply, ev_cur_act, ev_cur_lp, ev_ov, ev_uv, ev_warn, ev_tfault;
  logic trip, lp_enter, lp_exit, is_lp;

  // Threshold registers: a write is picked up by the very next comparison.
  generate
    for (genvar i = 0; i < THR_COUNT; i++) begin : g_thr
      always_comb begin
        thr_d[i] = thr_q[i];
        if (reg_wr && thr_index(reg_addr) == i) begin
          thr_d[i] = reg_wdata; // RQ21
        end
      end
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          thr_q[i] <= (i == THR_SUPPLY || i == THR_PACK_UV || i >= THR_TEMP_WARN) ?
                      RST_THR_LOW : RST_THR_HIGH;
        end else begin
          thr_q[i] <= thr_d[i];
        end
      end
    end
  endgenerate

  // Mode edges and the compare events; temperature codes fall as the die heats.
  always_comb begin
    is_lp = (mode == MODE_LOWPOWER);
    lp_enter = is_lp && (mode_prev_q != MODE_LOWPOWER); // RQ7
    lp_exit = !is_lp && (mode_prev_q == MODE_LOWPOWER);
    ev_supply = meas.valid && meas.kind == MEAS_REG && meas.value_a < thr_q[THR_SUPPLY]; // RQ1
    ev_cur_act = 1'b0;
    ev_cur_lp = 1'b0;
    case (mode)
      MODE_IDLE, MODE_SCAN: begin
        ev_cur_act = meas.valid && meas.kind == MEAS_REG &&
                     meas.value_b > thr_q[THR_CUR_ACT]; // RQ3
      end
      MODE_LOWPOWER: begin
        // Checked on each low power measurement and once the entry timer runs out.
        ev_cur_lp = (meas.valid && meas.kind == MEAS_REG &&
                     meas.value_b > thr_q[THR_CUR_LP]) ||
                    (lp_pend_q && lp_cnt_q == '0 &&
                     shadow_q.reg_current > thr_q[THR_CUR_LP]); // RQ5 RQ6
      end
      default: begin
        ev_cur_act = 1'b0;
      end
    endcase
    ev_ov = meas.valid && meas.kind == MEAS_PACK && meas.value_a > thr_q[THR_PACK_OV]; // RQ9
    ev_uv = meas.valid && meas.kind == MEAS_PACK && meas.value_a < thr_q[THR_PACK_UV]; // RQ11
    ev_warn = meas.valid && meas.kind == MEAS_TEMP &&
              meas.value_a < thr_q[THR_TEMP_WARN]; // RQ13
    ev_tfault = meas.valid && meas.kind == MEAS_TEMP &&
                meas.value_a < thr_q[THR_TEMP_FAULT]; // RQ13
    // The warning is left out on purpose: it must never open a switch.
    trip = ev_supply || ev_cur_act || ev_tfault || // RQ2 RQ4 RQ18 RQ14
           (ev_ov && charge_current_seen) || // RQ10
           (ev_uv && discharge_current_seen); // RQ12
  end

  // Sticky flags: a new event in the clearing cycle wins over the clear.
  always_comb begin
    supply_low_fault_d = ev_supply | (supply_low_fault_q & ~fault_clear); // RQ20
    reg_overcurrent_active_fault_d = ev_cur_act |
                                     (reg_overcurrent_active_fault_q & ~fault_clear);
    reg_overcurrent_lowpower_fault_d = ev_cur_lp |
                                       (reg_overcurrent_lowpower_fault_q & ~fault_clear);
    pack_over_voltage_fault_d = ev_ov | (pack_over_voltage_fault_q & ~fault_clear);
    pack_under_voltage_fault_d = ev_uv | (pack_under_voltage_fault_q & ~fault_clear);
    die_temp_warning_d = ev_warn | (die_temp_warning_q & ~fault_clear);
    die_temp_fault_d = ev_tfault | (die_temp_fault_q & ~fault_clear);
    // Pump readiness is a status, not a fault, so only the mode clears it.
    pump_not_ready_d = pump_not_ready_q;
    if (lp_enter && pump_enabled) begin
      pump_not_ready_d = 1'b1; // RQ7
    end else if (lp_exit) begin
      pump_not_ready_d = 1'b0; // RQ8
    end
  end

  // Switches and scan; a trip outranks every host request in the same cycle.
  always_comb begin
    chg_sw_d = chg_sw_q;
    dis_sw_d = dis_sw_q;
    chg_save_d = chg_save_q;
    dis_save_d = dis_save_q;
    scan_d = scan_q;
    if (scan_stop_req || mode != MODE_SCAN) begin
      scan_d = 1'b0;
    end else if (scan_start_req && !die_temp_fault_q) begin
      scan_d = 1'b1; // RQ19
    end
    if (switch_off_req) begin
      chg_sw_d = 1'b0;
      dis_sw_d = 1'b0;
    end else if (switch_on_req && !die_temp_fault_q && !is_lp) begin
      chg_sw_d = 1'b1; // RQ19
      dis_sw_d = 1'b1;
    end
    if (lp_enter && pump_enabled) begin
      // Remember the switches so the return to idle can restore them.
      chg_save_d = chg_sw_q;
      dis_save_d = dis_sw_q;
      chg_sw_d = 1'b0;
      dis_sw_d = 1'b0;
    end else if (lp_exit && pump_not_ready_q && !die_temp_fault_q) begin
      chg_sw_d = chg_save_q; // RQ8
      dis_sw_d = dis_save_q;
    end
    if (trip) begin
      chg_sw_d = 1'b0; // RQ2 RQ4 RQ10 RQ12 RQ18
      dis_sw_d = 1'b0;
      scan_d = 1'b0;
    end
  end

  // Results: low power readings go to a shadow only and are published on exit.
  always_comb begin
    shadow_d = shadow_q;
    res_d = res_q;
    if (meas.valid) begin
      case (meas.kind)
        MEAS_REG: begin
          shadow_d.supply = meas.value_a; // RQ15
          shadow_d.reg_current = meas.value_b;
        end
        MEAS_PACK: shadow_d.pack = meas.value_a; // RQ16
        MEAS_TEMP: shadow_d.temp = meas.value_a; // RQ17
        default: shadow_d = shadow_q;
      endcase
    end
    if (!is_lp) begin
      res_d = lp_exit ? shadow_q : shadow_d;
    end
  end

  // Entry timer bounds the first low power overcurrent check to the evaluation time.
  always_comb begin
    lp_cnt_d = lp_cnt_q;
    lp_pend_d = lp_pend_q;
    if (lp_enter) begin
      lp_cnt_d = TW'(LP_EVAL_CYCLES - 1); // RQ6
      lp_pend_d = 1'b1;
    end else if (!is_lp || lp_cnt_q == '0) begin
      lp_pend_d = 1'b0;
    end else begin
      lp_cnt_d = lp_cnt_q - TW'(1);
    end
  end

  // Register read data, taken one cycle after the read strobe.
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      rdata_d = '0;
      if (thr_index(reg_addr) != THR_COUNT) begin
        rdata_d = thr_q[thr_index(reg_addr)]; // RQ21
      end else begin
        case (reg_addr)
          OFS_STAT_63: begin
            rdata_d[BIT_SUPPLY_LOW] = supply_low_fault_q;
            rdata_d[BIT_TEMP_FAULT] = die_temp_fault_q;
          end
          OFS_STAT_65: begin
            rdata_d[BIT_PACK_OV] = pack_over_voltage_fault_q;
            rdata_d[BIT_PACK_UV] = pack_under_voltage_fault_q;
            rdata_d[BIT_PUMP_NRDY] = pump_not_ready_q;
          end
          OFS_STAT_66: rdata_d[BIT_TEMP_WARN] = die_temp_warning_q;
          OFS_STAT_67: begin
            rdata_d[BIT_DISCHG_SEEN] = discharge_current_seen;
            rdata_d[BIT_CHG_SEEN] = charge_current_seen;
            rdata_d[BIT_REG_OC_ACT] = reg_overcurrent_active_fault_q;
            rdata_d[BIT_REG_OC_LP] = reg_overcurrent_lowpower_fault_q;
          end
          default: rdata_d = '0;
        endcase
      end
    end
  end

  // State registers.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
      supply_low_fault_q <= 1'b0;
      reg_overcurrent_active_fault_q <= 1'b0;
      reg_overcurrent_lowpower_fault_q <= 1'b0;
      pack_over_voltage_fault_q <= 1'b0;
      pack_under_voltage_fault_q <= 1'b0;
      die_temp_warning_q <= 1'b0;
      die_temp_fault_q <= 1'b0;
      pump_not_ready_q <= 1'b0;
      chg_sw_q <= 1'b0;
      dis_sw_q <= 1'b0;
      chg_save_q <= 1'b0;
      dis_save_q <= 1'b0;
      scan_q <= 1'b0;
      mode_prev_q <= MODE_IDLE;
      res_q <= '0;
      shadow_q <= '0;
      lp_cnt_q <= '0;
      lp_pend_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      supply_low_fault_q <= supply_low_fault_d;
      reg_overcurrent_active_fault_q <= reg_overcurrent_active_fault_d;
      reg_overcurrent_lowpower_fault_q <= reg_overcurrent_lowpower_fault_d;
      pack_over_voltage_fault_q <= pack_over_voltage_fault_d;
      pack_under_voltage_fault_q <= pack_under_voltage_fault_d;
      die_temp_warning_q <= die_temp_warning_d;
      die_temp_fault_q <= die_temp_fault_d;
      pump_not_ready_q <= pump_not_ready_d;
      chg_sw_q <= chg_sw_d;
      dis_sw_q <= dis_sw_d;
      chg_save_q <= chg_save_d;
      dis_save_q <= dis_save_d;
      scan_q <= scan_d;
      mode_prev_q <= mode;
      res_q <= res_d;
      shadow_q <= shadow_d;
      lp_cnt_q <= lp_cnt_d;
      lp_pend_q <= lp_pend_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign charge_switch = chg_sw_q;
  assign discharge_switch = dis_sw_q;
  assign scan_running = scan_q;
  assign results = res_q;

endmodule

/* File: spfm_monitor_bench.sv */
// Random and directed bench of the monitor against a behavioural model.
`timescale 1ns/10ps
module spfm_monitor_bench;
  import spfm_pkg::*;
  localparam int LPC = 16;
  logic ref_clk, rst_b, reg_wr, reg_rd, chg, dis, pump, trip;
  logic [7:0] reg_addr, rv;
  logic [DW-1:0] reg_wdata, reg_rdata;
  logic [4:0] ctrl;
  logic charge_switch, discharge_switch, scan_running;
  logic [15:0] seed;
  spfm_mode_t mode;
  spfm_meas_in_t meas;
  spfm_results_t results;
  int fail_count, compares;
  int thr[$] = '{0, 255, 255, 255, 0, 0, 0};
  int res[$] = '{0, 0, 0, 0};
  logic [7:0] ofs[$] = '{8'h1C, 8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h23};
  logic [7:0] sofs[$] = '{8'h63, 8'h65, 8'h66, 8'h67};
  spfm_meas_t kinds[3] = '{MEAS_REG, MEAS_PACK, MEAS_TEMP};
  bit f_sup, f_oc1, f_oc2, f_ov, f_uv, f_tw, f_tf, pnr, sw, scan;
  spfm_monitor #(.LP_EVAL_CYCLES(LPC)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode(mode), .meas(meas),
    .charge_current_seen(chg), .discharge_current_seen(dis), .pump_enabled(pump),
    .fault_clear(ctrl[4]), .switch_on_req(ctrl[3]), .switch_off_req(ctrl[2]),
    .scan_start_req(ctrl[1]), .scan_stop_req(ctrl[0]), .charge_switch(charge_switch),
    .discharge_switch(discharge_switch), .scan_running(scan_running), .results(results));
  spfm_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl(ctrl));
  // Free running 200 MHz clock.
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'h0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
  endfunction
  function automatic logic [7:0] stat(input int i);
    case (i)
      0: return {f_sup, 1'h0, f_tf, 5'h00};
      1: return {f_ov, f_uv, pnr, 5'h00};
      2: return {1'h0, f_tw, 6'h00};
      default: return {dis, chg, 3'h0, f_oc1, f_oc2, 1'h0};
    endcase
  endfunction
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Switch state, results and the status bytes; the current-seen bits follow chg and dis.
  task automatic check_all;
    chk("charge_switch", 8'(charge_switch), 8'(sw));
    chk("discharge_switch", 8'(discharge_switch), 8'(sw));
    chk("scan_running", 8'(scan_running), 8'(scan));
    for (int i = 0; i < 4; i++) begin
      chk("result", results[31 - 8 * i -: 8], 8'(res[i]));
      host.rd(sofs[i], rv);
      chk("status", rv, stat(i));
    end
  endtask
  task automatic set_thr(input int i, input logic [7:0] v);
    host.wr(ofs[i], v);
    thr[i] = v;
  endtask
  task automatic ctl(input logic [4:0] p);
    host.pulse(p);
    if (p[4]) {f_sup, f_oc1, f_oc2, f_ov, f_uv, f_tw, f_tf} = 7'h00;
    // Off outranks on, and a stop or a mode other than scan outranks a start.
    if (p[2]) sw = 1'h0;
    else if (p[3] && !f_tf) sw = 1'h1;
    if (p[0] || mode != MODE_SCAN) scan = 1'h0;
    else if (p[1] && !f_tf) scan = 1'h1;
  endtask
  // One measurement for one cycle; the model keeps sticky bits and trips.
  task automatic do_meas(input spfm_meas_t k, input int a, input int b);
    @(negedge ref_clk);
    meas = {1'h1, k, 8'(a), 8'(b)};
    @(negedge ref_clk);
    meas = {1'h0, k, ~8'(a), ~8'(b)};
    if (k == MEAS_REG) begin
      res[0] = a;
      res[1] = b;
      trip = a < thr[0] || b > thr[1];
      f_sup |= a < thr[0];
      f_oc1 |= b > thr[1];
    end else if (k == MEAS_PACK) begin
      res[2] = a;
      trip = (a > thr[3] && chg) || (a < thr[4] && dis);
      f_ov |= a > thr[3];
      f_uv |= a < thr[4];
    end else begin
      res[3] = a;
      trip = a < thr[6];
      f_tw |= a < thr[5];
      f_tf |= a < thr[6];
    end
    if (trip) begin
      sw = 1'h0;
      scan = 1'h0;
    end
  endtask
  // Main sequence: reset, limits, low power, then random traffic.
  initial begin
    rst_b = 1'h0;
    mode = MODE_IDLE;
    meas = '0;
    chg = 1'h0;
    dis = 1'h0;
    pump = 1'h0;
    seed = 16'hAC38;
    repeat (20) @(negedge ref_clk);
    rst_b = 1'h1;
    check_all;
    for (int i = 0; i < 8; i++) begin
      host.rd(i < 7 ? ofs[i] : 8'h00, rv);
      chk("threshold", rv, i < 7 ? 8'(thr[i]) : 8'h00);
    end
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      set_thr(i, seed[7:0]);
      host.rd(ofs[i], rv);
      chk("threshold", rv, 8'(thr[i]));
    end
    set_thr(0, 8'h00);
    set_thr(1, 8'hFF);
    set_thr(2, 8'h10);
    ctl(5'h10);
    ctl(5'h08);
    do_meas(MEAS_REG, 255, 64);
    check_all;
    pump = 1'h1;
    mode = MODE_LOWPOWER;
    repeat (LPC + 4) @(negedge ref_clk);
    {f_oc2, pnr, sw} = 3'h6;
    check_all;
    mode = MODE_IDLE;
    repeat (2) @(negedge ref_clk);
    {pnr, sw} = 2'h1;
    check_all;
    pump = 1'h0;
    for (int n = 0; n < 80; n++) begin
      seed = lfsr(seed);
      mode = seed[0] ? MODE_SCAN : MODE_IDLE;
      chg = seed[1];
      dis = seed[2] & ~seed[1];
      if (!seed[0]) scan = 1'h0;
      if (seed[3]) set_thr(int'(seed[6:4]) % 7, seed[15:8]);
      if (!sw || (seed[0] && !scan)) begin
        ctl(5'h08);
        ctl(5'h02);
        check_all;
        ctl(5'h10);
        ctl(5'h08);
        ctl(5'h02);
      end
      // Host stop when seed[7] is set, with switch off too when seed[5] is set, so both requests reach the design.
      if (seed[7]) ctl({2'h0, seed[5], 1'h0, 1'h1});
      seed = lfsr(seed);
      do_meas(kinds[int'(seed[1:0]) % 3], seed[15:8], seed[7:0]);
      check_all;
    end
    tally_and_finish;
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish;
  end
endmodule

/* File: spfm_monitor_sva.sv */
// Checker of switch, scan and threshold read behaviour at the monitor ports.
`timescale 1ns/10ps
module spfm_monitor_sva
  import spfm_pkg::*;
#(
  parameter int LP_EVAL_CYCLES = LP_EVAL_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  input wire spfm_mode_t mode,
  input wire spfm_meas_in_t meas,
  input wire logic charge_current_seen,
  input wire logic discharge_current_seen,
  input wire logic switch_off_req,
  input wire logic scan_stop_req,
  input wire logic charge_switch,
  input wire logic discharge_switch,
  input wire logic scan_running
);
  logic [DW-1:0] thr_q [THR_COUNT];
  logic [DW-1:0] thr_d [THR_COUNT];
  logic [DW-1:0] rd_exp, va, vb;
  logic hit, is_reg, is_pack, is_temp;
  int idx;
  // Mirror of the limits, so each check uses the one in force at that edge.
  always_comb begin
    idx = (reg_addr < 8'h1F) ? int'(reg_addr) - 28 : int'(reg_addr) - 29;
    hit = reg_addr >= OFS_SUPPLY_MIN && reg_addr <= OFS_TEMP_FAULT && reg_addr != 8'h1F;
    rd_exp = hit ? thr_q[idx] : 8'h00;
    thr_d = thr_q;
    if (reg_wr && hit) thr_d[idx] = reg_wdata;
    va = meas.value_a;
    vb = meas.value_b;
    is_reg = meas.valid && meas.kind == MEAS_REG;
    is_pack = meas.valid && meas.kind == MEAS_PACK;
    is_temp = meas.valid && meas.kind == MEAS_TEMP;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      thr_q <= '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    end else begin
      thr_q <= thr_d;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // A trip opens both switches and stops scanning one cycle after the result.
  sequence s_off;
    !charge_switch && !discharge_switch && !scan_running;
  endsequence
  property p_supply_trip;
    is_reg && va < thr_q[THR_SUPPLY] |=> s_off;
  endproperty
  a_supply_trip: assert property (p_supply_trip)
    else $error("supply low did not trip");
  property p_oc_trip;
    is_reg && mode != MODE_LOWPOWER && vb > thr_q[THR_CUR_ACT] |=> s_off;
  endproperty
  a_oc_trip: assert property (p_oc_trip)
    else $error("overcurrent did not trip");
  property p_ov_trip;
    is_pack && va > thr_q[THR_PACK_OV] && charge_current_seen |=> s_off;
  endproperty
  a_ov_trip: assert property (p_ov_trip)
    else $error("overvoltage did not trip");
  property p_uv_trip;
    is_pack && va < thr_q[THR_PACK_UV] && discharge_current_seen |=> s_off;
  endproperty
  a_uv_trip: assert property (p_uv_trip)
    else $error("undervoltage did not trip");
  property p_temp_trip;
    is_temp && va < thr_q[THR_TEMP_FAULT] |=> s_off;
  endproperty
  a_temp_trip: assert property (p_temp_trip)
    else $error("temperature fault did not trip");
  property p_warn_only;
    is_temp && va >= thr_q[THR_TEMP_FAULT] && mode == MODE_SCAN && charge_switch
      && scan_running && !switch_off_req && !scan_stop_req |=> charge_switch && scan_running;
  endproperty
  a_warn_only: assert property (p_warn_only)
    else $error("warning changed switches or scan");
  property p_pack_stay;
    is_pack && !charge_current_seen && !discharge_current_seen && charge_switch
      && mode != MODE_LOWPOWER && !switch_off_req |=> charge_switch && discharge_switch;
  endproperty
  a_pack_stay: assert property (p_pack_stay)
    else $error("pack fault without current opened switches");
  property p_thr_read;
    reg_rd && hit ##1 !reg_rd |=> reg_rdata == $past(rd_exp, 2);
  endproperty
  a_thr_read: assert property (p_thr_read)
    else $error("threshold read back wrong");
endmodule
bind spfm_monitor spfm_monitor_sva #(.LP_EVAL_CYCLES(LP_EVAL_CYCLES)) u_sva (
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode(mode), .meas(meas),
  .charge_current_seen(charge_current_seen), .discharge_current_seen(discharge_current_seen),
  .switch_off_req(switch_off_req), .scan_stop_req(scan_stop_req),
  .charge_switch(charge_switch), .discharge_switch(discharge_switch),
  .scan_running(scan_running)
);

/* File: spfm_pkg.sv */
// Package with offsets, field positions, reset values, timing and types of the fault monitor.
package spfm_pkg;

  // Width of one measurement result and of one threshold register.
  localparam int DW = 8;

  // Threshold register offsets.
  localparam logic [7:0] OFS_SUPPLY_MIN = 8'h1C;
  localparam logic [7:0] OFS_REG_CUR_ACT = 8'h1D;
  localparam logic [7:0] OFS_REG_CUR_LP = 8'h1E;
  localparam logic [7:0] OFS_PACK_OV = 8'h20;
  localparam logic [7:0] OFS_PACK_UV = 8'h21;
  localparam logic [7:0] OFS_TEMP_WARN = 8'h22;
  localparam logic [7:0] OFS_TEMP_FAULT = 8'h23;

  // Status register offsets.
  localparam logic [7:0] OFS_STAT_63 = 8'h63;
  localparam logic [7:0] OFS_STAT_65 = 8'h65;
  localparam logic [7:0] OFS_STAT_66 = 8'h66;
  localparam logic [7:0] OFS_STAT_67 = 8'h67;

  // Status bit positions.
  localparam int BIT_SUPPLY_LOW = 7;
  localparam int BIT_TEMP_FAULT = 5;
  localparam int BIT_PACK_OV = 7;
  localparam int BIT_PACK_UV = 6;
  localparam int BIT_PUMP_NRDY = 5;
  localparam int BIT_TEMP_WARN = 6;
  localparam int BIT_DISCHG_SEEN = 7;
  localparam int BIT_CHG_SEEN = 6;
  localparam int BIT_REG_OC_ACT = 2;
  localparam int BIT_REG_OC_LP = 1;

  // Index of each threshold in the threshold array.
  localparam int THR_SUPPLY = 0;
  localparam int THR_CUR_ACT = 1;
  localparam int THR_CUR_LP = 2;
  localparam int THR_PACK_OV = 3;
  localparam int THR_PACK_UV = 4;
  localparam int THR_TEMP_WARN = 5;
  localparam int THR_TEMP_FAULT = 6;
  localparam int THR_COUNT = 7;

  // Reset values: lower limits start at the bottom, upper limits at the top.
  localparam logic [DW-1:0] RST_THR_LOW = 8'h00;
  localparam logic [DW-1:0] RST_THR_HIGH = 8'hFF;

  // Low power evaluation time, longest time, rounded down to cycles.
  localparam int CLK_HZ = 200_000_000;
  localparam int LP_EVAL_MS = 256;
  localparam int LP_EVAL_CYC = LP_EVAL_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    MODE_IDLE = 3'b001,
    MODE_SCAN = 3'b010,
    MODE_LOWPOWER = 3'b100
  } spfm_mode_t;

  typedef enum logic [2:0] {
    MEAS_REG = 3'b001,
    MEAS_PACK = 3'b010,
    MEAS_TEMP = 3'b100
  } spfm_meas_t;

  // One finished measurement; a regulator result carries supply in value_a, current in value_b.
  typedef struct packed {
    logic valid;
    spfm_meas_t kind;
    logic [DW-1:0] value_a;
    logic [DW-1:0] value_b;
  } spfm_meas_in_t;

  // Stored measurement results as the host sees them.
  typedef struct packed {
    logic [DW-1:0] supply;
    logic [DW-1:0] reg_current;
    logic [DW-1:0] pack;
    logic [DW-1:0] temp;
  } spfm_results_t;

endpackage
